/* File: mspt_pkg.sv */
/*
 * mspt_pkg: register map, field positions, reset values and shared types
 * of the master/slave pulse timer pair.
 * Assumes a single 250 MHz clock and a plain strobe register port.
 */
package mspt_pkg;
    // ------------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PCLK = 8'h00;
    localparam logic [7:0] OFF_TRIG = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_MRLD = 8'h0C;
    localparam logic [7:0] OFF_SRLD = 8'h10;
    localparam logic [7:0] OFF_MCNT = 8'h14;
    localparam logic [7:0] OFF_SCNT = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1C;
    localparam logic [7:0] OFF_TOUT = 8'h20;
    localparam logic [7:0] OFF_ISTA = 8'h24;
    localparam logic [7:0] OFF_ICLR = 8'h28;
    localparam logic [7:0] OFF_IENA = 8'h2C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PCLK_UNIT0 = 0;
    localparam int TRIG_START = 0;
    localparam int TRIG_STOP = 1;
    localparam int MODE_ONESHOT = 0;
    localparam int MODE_EDGE_LO = 1;
    localparam int MODE_EDGE_HI = 2;
    localparam int MODE_SWSTART = 3;
    localparam int MODE_LEVEL = 4;
    localparam int TOUT_VAL = 0;
    localparam int TOUT_OE = 1;
    localparam int IRQ_MASTER = 0;
    localparam int IRQ_SLAVE = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PCLK_RST = 8'h00;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [15:0] RLD_RST = 16'h0000;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        MSPT_EDGE_FALL = 2'b00,
        MSPT_EDGE_RISE = 2'b01,
        MSPT_EDGE_BOTH = 2'b10,
        MSPT_EDGE_ANY = 2'b11
    } mspt_edge_e;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } mspt_req_s;

    // timer pin group
    typedef struct packed {
        logic out;
        logic oe;
    } mspt_pin_s;
endpackage : mspt_pkg

/* File: mspt_chan_cnt.sv */
/*
 * mspt_chan_cnt: one channel down counter with load, decrement and clear.
 * Assumes the parent decides when to load and when to count.
 */
`timescale 1ns/10ps
module mspt_chan_cnt #(
    parameter int CNT_W = mspt_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic clr,
    input wire logic load,
    input wire logic dec,
    input wire logic [CNT_W-1:0] reload,
    // state
    output logic [CNT_W-1:0] count,
    output logic is_zero
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } mspt_cnt_s;

    mspt_cnt_s st_ff;
    mspt_cnt_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (clr) begin
            nxt_st.cnt = '0;
        end else if (load) begin
            nxt_st.cnt = reload;
        end else if (dec && (st_ff.cnt != '0)) begin
            nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.cnt;
    assign is_zero = (st_ff.cnt == '0);
endmodule // mspt_chan_cnt

/* File: mspt_pair.sv */
/*
 * mspt_pair: master/slave channel pair producing PWM or one-shot pulses.
 * Assumes one clock, a plain strobe register port, and a timer input pin
 * that is asynchronous and is synchronised here.
 */
// Design decisions made here: the plain strobed port and the placing of the registers.
// How it works
// - start and stop trigger bits self-clear, they always read back zero
// - in pwm the master raises its interrupt as it starts, starting slave
// - pwm master loads reload, counts down, at zero interrupts and reloads
// - each master interrupt loads the slave reload into the slave counter
// - slave output active one count after interrupt, off and stop at zero
// - both counters always readable; channel status (enables, wait, run, output) reads from STAT
// - stop clears both enable flags, counters and output level hold
// - unit enable low resets every circuit but the clock enables and the input synchroniser and returns pin to port mode
// - one-shot start sets both enables, master waits for an input edge or, with sw_start, loads at once
// - one-shot master loads on trigger, at zero interrupts and waits
// - the slave is channel n+1 of an even master channel n
// - without an input pin the master uses software trigger start only
`timescale 1ns/10ps
module mspt_pair #(
    parameter int MASTER_CH = 0,
    parameter bit HAS_INPUT_PIN = 1'b1
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire mspt_pkg::mspt_req_s req,
    output logic [mspt_pkg::DATA_W-1:0] rdata,
    // timer pins
    input wire logic master_input_pin,
    output mspt_pkg::mspt_pin_s slave_pin,
    // interrupts
    output logic master_period_interrupt,
    output logic irq
);
    localparam int SLAVE_CH = MASTER_CH + 1;
    localparam int CW = mspt_pkg::CNT_W;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pclk;
        logic [4:0] mode;
        logic [CW-1:0] m_reload;
        logic [CW-1:0] s_reload;
        logic en_m;
        logic en_s;
        logic m_wait;
        logic m_run;
        logic s_run;
        logic s_out;
        logic oe;
        logic m_pulse;
        logic s_pulse;
        logic [mspt_pkg::IRQ_W-1:0] ista;
        logic [mspt_pkg::IRQ_W-1:0] iena;
        logic sync1;
        logic sync2;
        logic prev;
        logic [mspt_pkg::DATA_W-1:0] rdata;
    } mspt_st_s;

    mspt_st_s st_ff;
    mspt_st_s nxt_st;

    logic [CW-1:0] m_count;
    logic [CW-1:0] s_count;
    logic m_zero;
    logic s_zero;
    logic m_load;
    logic m_dec;
    logic s_load;
    logic s_dec;
    logic unit_off;

    function automatic logic hit(input logic [mspt_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // channel counters
    // ------------------------------------------------------------------
    mspt_chan_cnt #(.CNT_W(CW)) u_master (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .clr(unit_off),
        .load(m_load),
        .dec(m_dec),
        .reload(st_ff.m_reload),
        .count(m_count),
        .is_zero(m_zero)
    );

    mspt_chan_cnt #(.CNT_W(CW)) u_slave (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .clr(unit_off),
        .load(s_load),
        .dec(s_dec),
        .reload(st_ff.s_reload),
        .count(s_count),
        .is_zero(s_zero)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic wr_trig;
    logic start;
    logic stop;
    logic oneshot;
    logic sw_start;
    logic edge_ok;
    logic rise;
    logic fall;
    mspt_pkg::mspt_edge_e esel;

    always_comb begin
        nxt_st = st_ff;
        m_load = 1'b0;
        m_dec = 1'b0;
        s_load = 1'b0;
        s_dec = 1'b0;
        wr_trig = req.wr && hit(req.addr, mspt_pkg::OFF_TRIG);
        // triggers act for the write cycle only and are never stored
        start = wr_trig && req.wdata[mspt_pkg::TRIG_START];
        stop = wr_trig && req.wdata[mspt_pkg::TRIG_STOP];
        oneshot = st_ff.mode[mspt_pkg::MODE_ONESHOT];
        // no pin means the start trigger is the only trigger
        sw_start = st_ff.mode[mspt_pkg::MODE_SWSTART] || !HAS_INPUT_PIN;
        esel = mspt_pkg::mspt_edge_e'(
            st_ff.mode[mspt_pkg::MODE_EDGE_HI:mspt_pkg::MODE_EDGE_LO]);
        rise = st_ff.sync2 && !st_ff.prev;
        fall = !st_ff.sync2 && st_ff.prev;
        case (esel)
            mspt_pkg::MSPT_EDGE_FALL: edge_ok = fall;
            mspt_pkg::MSPT_EDGE_RISE: edge_ok = rise;
            mspt_pkg::MSPT_EDGE_BOTH: edge_ok = rise || fall;
            mspt_pkg::MSPT_EDGE_ANY: edge_ok = rise || fall;
            default: edge_ok = 1'b0;
        endcase
        edge_ok = edge_ok && HAS_INPUT_PIN;

        nxt_st.sync1 = master_input_pin;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev = st_ff.sync2;
        nxt_st.m_pulse = 1'b0;
        nxt_st.s_pulse = 1'b0;

        // master channel
        if (st_ff.m_run && st_ff.en_m) begin
            if (m_zero) begin
                nxt_st.m_pulse = 1'b1;
                if (oneshot) begin
                    nxt_st.m_run = 1'b0;
                    nxt_st.m_wait = 1'b1;
                end else begin
                    m_load = 1'b1;
                end
            end else begin
                m_dec = 1'b1;
            end
        end else if (st_ff.m_wait && st_ff.en_m && edge_ok) begin
            // edges that arrive while counting are ignored
            m_load = 1'b1;
            nxt_st.m_run = 1'b1;
            nxt_st.m_wait = 1'b0;
        end

        // slave channel, driven only by the master interrupt
        if (st_ff.m_pulse && st_ff.en_s) begin
            s_load = 1'b1;
            nxt_st.s_run = 1'b1;
            nxt_st.s_out = 1'b1;
        end else if (st_ff.s_run && st_ff.en_s) begin
            if (s_zero) begin
                nxt_st.s_run = 1'b0;
                nxt_st.s_out = 1'b0;
                nxt_st.s_pulse = 1'b1;
            end else begin
                s_dec = 1'b1;
            end
        end

        // triggers; stop wins over start in the same write
        if (stop) begin
            nxt_st.en_m = 1'b0;
            nxt_st.en_s = 1'b0;
            nxt_st.m_run = 1'b0;
            nxt_st.m_wait = 1'b0;
            nxt_st.s_run = 1'b0;
            nxt_st.s_out = st_ff.s_out;
            nxt_st.m_pulse = 1'b0;
            m_load = 1'b0;
            m_dec = 1'b0;
            s_load = 1'b0;
            s_dec = 1'b0;
        end else if (start) begin
            nxt_st.en_m = 1'b1;
            nxt_st.en_s = 1'b1;
            if (!oneshot) begin
                m_load = 1'b1;
                m_dec = 1'b0;
                nxt_st.m_run = 1'b1;
                nxt_st.m_wait = 1'b0;
                nxt_st.m_pulse = 1'b1;
            end else if (sw_start) begin
                m_load = 1'b1;
                m_dec = 1'b0;
                nxt_st.m_run = 1'b1;
                nxt_st.m_wait = 1'b0;
            end else begin
                m_dec = 1'b0;
                m_load = 1'b0;
                nxt_st.m_run = 1'b0;
                nxt_st.m_wait = 1'b1;
            end
        end

        // register writes
        if (req.wr) begin
            if (hit(req.addr, mspt_pkg::OFF_PCLK)) begin
                nxt_st.pclk = req.wdata[7:0];
            end
            if (hit(req.addr, mspt_pkg::OFF_MODE)) begin
                nxt_st.mode = req.wdata[4:0];
            end
            if (hit(req.addr, mspt_pkg::OFF_MRLD)) begin
                nxt_st.m_reload = req.wdata[CW-1:0];
            end
            if (hit(req.addr, mspt_pkg::OFF_SRLD)) begin
                nxt_st.s_reload = req.wdata[CW-1:0];
            end
            if (hit(req.addr, mspt_pkg::OFF_TOUT)) begin
                nxt_st.oe = req.wdata[mspt_pkg::TOUT_OE];
                // a level write never fights a running or starting slave
                if (!nxt_st.s_run) begin
                    nxt_st.s_out = req.wdata[mspt_pkg::TOUT_VAL];
                end
            end
            if (hit(req.addr, mspt_pkg::OFF_IENA)) begin
                nxt_st.iena = req.wdata[mspt_pkg::IRQ_W-1:0];
            end
        end

        // sticky events: a new event beats a clear in the same cycle
        nxt_st.ista = st_ff.ista;
        if (req.wr && hit(req.addr, mspt_pkg::OFF_ICLR)) begin
            nxt_st.ista = st_ff.ista & ~req.wdata[mspt_pkg::IRQ_W-1:0];
        end
        nxt_st.ista[mspt_pkg::IRQ_MASTER] =
            nxt_st.ista[mspt_pkg::IRQ_MASTER] | nxt_st.m_pulse;
        nxt_st.ista[mspt_pkg::IRQ_SLAVE] =
            nxt_st.ista[mspt_pkg::IRQ_SLAVE] | nxt_st.s_pulse;

        // read data, one cycle after the strobe
        nxt_st.rdata = '0;
        if (req.rd) begin
            case (req.addr)
                mspt_pkg::OFF_PCLK: nxt_st.rdata = {8'h00, st_ff.pclk};
                mspt_pkg::OFF_MODE: nxt_st.rdata = {11'h000, st_ff.mode};
                mspt_pkg::OFF_MRLD: nxt_st.rdata = st_ff.m_reload;
                mspt_pkg::OFF_SRLD: nxt_st.rdata = st_ff.s_reload;
                mspt_pkg::OFF_MCNT: nxt_st.rdata = m_count;
                mspt_pkg::OFF_SCNT: nxt_st.rdata = s_count;
                mspt_pkg::OFF_STAT: nxt_st.rdata = {10'h000, st_ff.s_out,
                    st_ff.s_run, st_ff.m_run, st_ff.m_wait, st_ff.en_s,
                    st_ff.en_m};
                mspt_pkg::OFF_TOUT: nxt_st.rdata = {14'h0000, st_ff.oe,
                    st_ff.s_out};
                mspt_pkg::OFF_ISTA: nxt_st.rdata = {14'h0000, st_ff.ista};
                mspt_pkg::OFF_IENA: nxt_st.rdata = {14'h0000, st_ff.iena};
                default: nxt_st.rdata = '0;
            endcase
        end

        // unit powered off: everything but the clock enables and the input synchroniser goes home
        if (!st_ff.pclk[mspt_pkg::PCLK_UNIT0]) begin
            nxt_st = '0;
            nxt_st.pclk = st_ff.pclk;
            nxt_st.sync1 = master_input_pin;
            nxt_st.sync2 = st_ff.sync1;
            nxt_st.prev = st_ff.sync2;
            if (req.wr && hit(req.addr, mspt_pkg::OFF_PCLK)) begin
                nxt_st.pclk = req.wdata[7:0];
            end
            if (req.rd && hit(req.addr, mspt_pkg::OFF_PCLK)) begin
                nxt_st.rdata = {8'h00, st_ff.pclk};
            end
            m_load = 1'b0;
            m_dec = 1'b0;
            s_load = 1'b0;
            s_dec = 1'b0;
        end
    end

    assign unit_off = !st_ff.pclk[mspt_pkg::PCLK_UNIT0];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // level bit inverts the active sense; pin released when unit is off
    assign slave_pin.out = st_ff.s_out ^ st_ff.mode[mspt_pkg::MODE_LEVEL];
    assign slave_pin.oe = st_ff.oe && !unit_off;
    assign master_period_interrupt = st_ff.m_pulse;
    assign irq = |(st_ff.ista & st_ff.iena);
    assign rdata = st_ff.rdata;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_trig_reads_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && req.rd && hit(req.addr, mspt_pkg::OFF_TRIG)) |=> (rdata == '0);
    endproperty
    a_trig_reads_zero: assert property (p_trig_reads_zero)
        else $error("trigger register did not read zero");

    property p_pwm_start_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && start && !stop && !oneshot && !unit_off)
        |=> master_period_interrupt && st_ff.en_s;
    endproperty
    a_pwm_start_irq: assert property (p_pwm_start_irq)
        else $error("pwm start raised no master interrupt");

    property p_pwm_reload;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && st_ff.m_run && st_ff.en_m && m_zero && !oneshot && !stop
         && !start && !unit_off)
        |=> (m_count == $past(st_ff.m_reload)) && master_period_interrupt;
    endproperty
    a_pwm_reload: assert property (p_pwm_reload)
        else $error("master did not reload at zero");

    property p_slave_load;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && master_period_interrupt && st_ff.en_s && !stop && !unit_off)
        |=> (s_count == $past(st_ff.s_reload)) && st_ff.s_out;
    endproperty
    a_slave_load: assert property (p_slave_load)
        else $error("slave did not load on master interrupt");

    property p_slave_end;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && st_ff.s_run && st_ff.en_s && s_zero && !master_period_interrupt
         && !stop && !unit_off) |=> !st_ff.s_out && !st_ff.s_run;
    endproperty
    a_slave_end: assert property (p_slave_end)
        else $error("slave output not cleared at zero");

    property p_stop_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && stop && !unit_off) |=> !st_ff.en_m && !st_ff.en_s
        && (st_ff.s_out == $past(st_ff.s_out))
        && (m_count == $past(m_count)) && (s_count == $past(s_count));
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop did not freeze the pair");

    property p_unit_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && unit_off) |=> (m_count == '0) && (s_count == '0)
        && !slave_pin.oe && !st_ff.en_m;
    endproperty
    a_unit_off: assert property (p_unit_off)
        else $error("unit off did not initialise the pair");

    property p_oneshot_wait;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && start && !stop && oneshot && !sw_start && !unit_off)
        |=> st_ff.en_m && st_ff.en_s && st_ff.m_wait
        && (m_count == $past(m_count));
    endproperty
    a_oneshot_wait: assert property (p_oneshot_wait)
        else $error("one-shot start did not wait for an edge");

    property p_oneshot_halt;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && oneshot && st_ff.m_run && st_ff.en_m && m_zero && !stop
         && !start && !unit_off)
        |=> st_ff.m_wait && !st_ff.m_run && master_period_interrupt;
    endproperty
    a_oneshot_halt: assert property (p_oneshot_halt)
        else $error("one-shot master did not halt at zero");

    c_pwm_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
        master_period_interrupt && !oneshot ##[1:40] master_period_interrupt);
    c_oneshot_edge: cover property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff.m_wait && edge_ok ##1 st_ff.m_run);
    c_slave_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff.s_out ##[1:40] !st_ff.s_out);
    c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) irq);
endmodule // mspt_pair

/* File: test_mspt_pair.sv */
/*
 * test_mspt_pair: self-checking bench for the master/slave pulse timer pair.
 * Assumes mspt_pkg and mspt_pair are compiled first; one 250 MHz clock.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_mspt_pair;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic pin = 1'b1;
    mspt_pkg::mspt_req_s req = '0;
    logic [15:0] rdata;
    mspt_pkg::mspt_pin_s slave_pin;
    logic mpi;
    logic irq;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hd93d_723d;
    logic [15:0] dm, ds, v0, v1;
    int lat, per, hi, np;
    logic [15:0] modes [4] = '{16'h0001, 16'h0003, 16'h0005, 16'h0009};

    always #2 clk_sys = ~clk_sys;

    mspt_pair dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .req(req),
        .rdata(rdata), .master_input_pin(pin), .slave_pin(slave_pin),
        .master_period_interrupt(mpi), .irq(irq));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // a count loaded with d spans d+1 count clocks
    function automatic int exp_len(input logic [15:0] d);
        return int'(d) + 1;
    endfunction
    task automatic draw(output logic [15:0] v, input int lo, input int span);
        seed = lfsr(seed);
        v = 16'(lo + int'(seed[7:0]) % span);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // latency to the next master pulse, then period and slave high time
    task automatic measure(output int l, output int p, output int h);
        l = 0;
        p = 0;
        h = 0;
        do begin @(negedge clk_sys); l++; end while (mpi !== 1'b1 && l < 300);
        do begin
            @(negedge clk_sys);
            p++;
            h += int'(slave_pin.out);
        end while (mpi !== 1'b1 && p < 300);
    endtask
    task print_verdict;
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard: whole run needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(mspt_pkg::OFF_PCLK, v0); `CHK(v0, 16'h0000)
        wr(mspt_pkg::OFF_MRLD, 16'h0055);
        rd(mspt_pkg::OFF_MRLD, v0); `CHK(v0, 16'h0000)
        wr(mspt_pkg::OFF_PCLK, 16'h0001);
        rd(mspt_pkg::OFF_PCLK, v0); `CHK(v0, 16'h0001)
        rd(mspt_pkg::OFF_MODE, v0); `CHK(v0, 16'h0000)
        rd(8'h3C, v0); `CHK(v0, 16'h0000)
        wr(mspt_pkg::OFF_IENA, 16'h0003);
        wr(mspt_pkg::OFF_TOUT, 16'h0002);
        // pwm: first pass is the shortest legal pair of counts
        for (int i = 0; i < 5; i++) begin
            dm = 16'h0001;
            ds = 16'h0000;
            if (i > 0) begin
                draw(dm, 3, 40);
                draw(ds, 0, int'(dm) - 1);
            end
            wr(mspt_pkg::OFF_MRLD, dm);
            wr(mspt_pkg::OFF_SRLD, ds);
            wr(mspt_pkg::OFF_TOUT, 16'h0002);
            wr(mspt_pkg::OFF_TRIG, 16'h0001);
            measure(lat, per, hi);
            `CHK(lat <= 2, 1'b1)
            `CHK(per, exp_len(dm))
            `CHK(hi, exp_len(ds))
            measure(lat, per, hi);
            `CHK(hi, exp_len(ds))
            `CHK(slave_pin.oe, 1'b1)
            rd(mspt_pkg::OFF_TRIG, v0); `CHK(v0, 16'h0000)
            wr(mspt_pkg::OFF_TRIG, 16'h0002);
            rd(mspt_pkg::OFF_STAT, v0); `CHK(v0[1:0], 2'b00)
            rd(mspt_pkg::OFF_MCNT, v1);
            repeat (5) @(posedge clk_sys);
            `CHK(slave_pin.out, v0[5])
            rd(mspt_pkg::OFF_MCNT, v0); `CHK(v0, v1)
            wr(mspt_pkg::OFF_TOUT, 16'h0000);
        end
        // interrupt: pending, masked, unmasked, cleared
        rd(mspt_pkg::OFF_ISTA, v0); `CHK(v0, 16'h0003)
        `CHK(irq, 1'b1)
        wr(mspt_pkg::OFF_IENA, 16'h0000);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        wr(mspt_pkg::OFF_IENA, 16'h0003);
        wr(mspt_pkg::OFF_ICLR, 16'h0003);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        // one-shot: fall, rise and both edge codes plus software start
        for (int m = 0; m < 4; m++) begin
            draw(dm, 3, 30);
            pin <= (modes[m] == 16'h0003) ? 1'b0 : 1'b1;
            wr(mspt_pkg::OFF_MODE, modes[m]);
            wr(mspt_pkg::OFF_MRLD, dm);
            wr(mspt_pkg::OFF_TRIG, 16'h0001);
            if (modes[m] != 16'h0009) begin
                rd(mspt_pkg::OFF_STAT, v0);
                `CHK(v0[2:0], 3'b111)
                @(posedge clk_sys);
                pin <= ~pin;
            end
            np = 0;
            repeat (3 * int'(dm) + 20) @(negedge clk_sys) np += int'(mpi);
            `CHK(np, 1)
            wr(mspt_pkg::OFF_TRIG, 16'h0002);
        end
        // power off returns everything but the input synchroniser to reset
        wr(mspt_pkg::OFF_TOUT, 16'h0000);
        wr(mspt_pkg::OFF_PCLK, 16'h0000);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(slave_pin, 2'b00)
        rd(mspt_pkg::OFF_MRLD, v0); `CHK(v0, 16'h0000)
        print_verdict();
    end
endmodule // test_mspt_pair
